/* File: logic/rpo_pkg.sv */
/*
  Shared constants and types for the resolver position output block:
  the angle counter, the serial read port and the encoder emulation.
  Assumes a 25 MHz system clock shared by both ends of the link.
*/
`default_nettype none

package rpo_pkg;

  localparam int ANGLE_W = 12;
  localparam int WORD_W = 16;
  localparam int FIFO_DEPTH = 16;
  localparam int TMR_W = 8;

  localparam int CLK_MHZ = 25;

  // Times in ns, converted to cycles with rounding up (least times).
  localparam int STEP_PULSE_NS = 300;
  localparam int STEP_PULSE_CYC = (STEP_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int SETUP_NS = 600;
  localparam int SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int HOLD_NS = 100;
  localparam int HOLD_CYC = (HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int GAP_NS = 250;
  localparam int GAP_CYC = (GAP_NS * CLK_MHZ + 999) / 1000;

  // Shift clock ceiling; each half period rounds up so the rate stays below.
  localparam int SCLK_MAX_KHZ = 2000;
  localparam int SCLK_HALF_CYC =
    (CLK_MHZ * 1000 + 2 * SCLK_MAX_KHZ - 1) / (2 * SCLK_MAX_KHZ);

  localparam logic [ANGLE_W-1:0] ANGLE_RST = 12'h000;
  localparam logic [4:0] FULL_BITS = 5'h0c;

  // Index width in counter steps; one A cycle is four steps.
  localparam logic [ANGLE_W-1:0] IDX_LSB_90 = 12'h001;
  localparam logic [ANGLE_W-1:0] IDX_LSB_180 = 12'h002;
  localparam logic [ANGLE_W-1:0] IDX_LSB_360 = 12'h004;

  // Codes of the three-level width select pin as seen by the logic.
  localparam logic [1:0] SEL_POS = 2'h0;
  localparam logic [1:0] SEL_GND = 2'h1;
  localparam logic [1:0] SEL_NEG = 2'h2;
  localparam logic [1:0] SEL_OPEN = 2'h3;
  localparam logic [1:0] SEL_RST = 2'h3;

  typedef enum logic [1:0] {
    RPO_W90,
    RPO_W180,
    RPO_W360
  } rpo_idx_w_e;

  typedef enum logic [2:0] {
    H_IDLE,
    H_SETUP,
    H_LOW,
    H_HIGH,
    H_HOLD,
    H_GAP
  } rpo_hst_e;

endpackage

`default_nettype wire

/* File: logic/rpo_if.sv */
/*
  Three-wire serial link between the position output device and the host.
  Assumes the open data wire reads low when nobody drives it.
*/
`timescale 1ns/1ns
`default_nettype none

interface rpo_if;
  logic cs_n;
  logic sclk;
  logic dev_data;
  logic dev_data_oe;
  logic data_line;

  // The wire level is resolved here so that no end needs a tri-state.
  assign data_line = dev_data_oe & dev_data;

  modport dev (
    input cs_n,
    input sclk,
    output dev_data,
    output dev_data_oe
  );

  modport host (
    output cs_n,
    output sclk,
    input data_line
  );
endinterface

`default_nettype wire

/* File: logic/rpo_device.sv */
/*
  Device end: 12-bit angle counter, serial read port and encoder emulation.
  Assumes step requests come from tracking loop logic on i_clk, while the
  select and shift clock arrive from the host asynchronously.
*/
`timescale 1ns/1ns
`default_nettype none

module rpo_device (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic i_step,
  input wire logic i_step_up,
  input wire logic i_sig_valid,
  input wire logic [1:0] i_idx_width_sel,
  rpo_if.dev link,
  output logic o_a,
  output logic o_b,
  output logic o_dir,
  output logic o_index_pulse,
  output logic o_lsb_step_pulse,
  output logic o_enc_valid,
  output logic [rpo_pkg::ANGLE_W-1:0] o_angle
);

  logic [rpo_pkg::ANGLE_W-1:0] angle_ff;
  logic [rpo_pkg::ANGLE_W-1:0] nxt_angle;
  logic dir_ff;
  logic [rpo_pkg::TMR_W-1:0] pulse_tmr_ff;
  logic pulse_ff;
  logic a_ff;
  logic b_ff;
  logic index_ff;
  logic valid_ff;
  logic [1:0] wsel_s1_ff;
  logic [1:0] wsel_s2_ff;
  rpo_pkg::rpo_idx_w_e idx_w;
  logic [rpo_pkg::ANGLE_W-1:0] idx_lsb;
  logic cs_s1_ff;
  logic cs_s2_ff;
  logic cs_d_ff;
  logic sclk_s1_ff;
  logic sclk_s2_ff;
  logic sclk_d_ff;
  logic cs_fall;
  logic sclk_fall;
  logic [rpo_pkg::ANGLE_W-1:0] shift_ff;
  logic data_ff;

  // The counter is the only position store; it is always current.
  always_comb
  begin
    nxt_angle = angle_ff;
    if (i_step)
    begin
      if (i_step_up)
        nxt_angle = angle_ff + 12'h001;
      else
        nxt_angle = angle_ff - 12'h001;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      angle_ff <= rpo_pkg::ANGLE_RST;
    else if (i_ce)
      angle_ff <= nxt_angle;
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      dir_ff <= 1'b1;
    else if (i_ce && i_step)
      dir_ff <= i_step_up;
  end

  // A step arriving during a pulse restarts it, so close steps merge into one
  // stretched pulse; at the rated step rate the pulse always ends first.
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      pulse_tmr_ff <= '0;
      pulse_ff <= 1'b0;
    end
    else if (i_ce)
    begin
      if (i_step)
      begin
        pulse_tmr_ff <= rpo_pkg::TMR_W'(rpo_pkg::STEP_PULSE_CYC - 1);
        pulse_ff <= 1'b1;
      end
      else if (pulse_tmr_ff != '0)
        pulse_tmr_ff <= pulse_tmr_ff - 8'h01;
      else
        pulse_ff <= 1'b0;
    end
  end

  // Encoder outputs follow the counter every step, no request needed.
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      a_ff <= 1'b0;
      b_ff <= 1'b0;
      index_ff <= 1'b0;
    end
    else if (i_ce)
    begin
      a_ff <= nxt_angle[1];
      b_ff <= nxt_angle[1] ^ nxt_angle[0];
      index_ff <= nxt_angle < idx_lsb;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      valid_ff <= 1'b0;
    else if (i_ce)
      valid_ff <= i_sig_valid;
  end

  // The width select is a static strap but still crosses in through two
  // flip-flops, since it may be moved by a jumper at any time.
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      wsel_s1_ff <= rpo_pkg::SEL_RST;
      wsel_s2_ff <= rpo_pkg::SEL_RST;
    end
    else if (i_ce)
    begin
      wsel_s1_ff <= i_idx_width_sel;
      wsel_s2_ff <= wsel_s1_ff;
    end
  end

  always_comb
  begin
    case (wsel_s2_ff)
      rpo_pkg::SEL_POS: idx_w = rpo_pkg::RPO_W90;
      rpo_pkg::SEL_GND: idx_w = rpo_pkg::RPO_W180;
      rpo_pkg::SEL_NEG: idx_w = rpo_pkg::RPO_W360;
      rpo_pkg::SEL_OPEN: idx_w = rpo_pkg::RPO_W90;
      default: idx_w = rpo_pkg::RPO_W90;
    endcase
  end

  always_comb
  begin
    case (idx_w)
      rpo_pkg::RPO_W90: idx_lsb = rpo_pkg::IDX_LSB_90;
      rpo_pkg::RPO_W180: idx_lsb = rpo_pkg::IDX_LSB_180;
      rpo_pkg::RPO_W360: idx_lsb = rpo_pkg::IDX_LSB_360;
      default: idx_lsb = rpo_pkg::IDX_LSB_90;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      cs_s1_ff <= 1'b1;
      cs_s2_ff <= 1'b1;
      cs_d_ff <= 1'b1;
      sclk_s1_ff <= 1'b1;
      sclk_s2_ff <= 1'b1;
      sclk_d_ff <= 1'b1;
    end
    else if (i_ce)
    begin
      cs_s1_ff <= link.cs_n;
      cs_s2_ff <= cs_s1_ff;
      cs_d_ff <= cs_s2_ff;
      sclk_s1_ff <= link.sclk;
      sclk_s2_ff <= sclk_s1_ff;
      sclk_d_ff <= sclk_s2_ff;
    end
  end

  assign cs_fall = cs_d_ff & ~cs_s2_ff;
  assign sclk_fall = sclk_d_ff & ~sclk_s2_ff;

  // The bit on the wire before the first fall is a void zero; each fall
  // then presents the next bit, and the empty shifter feeds zeros.
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      shift_ff <= '0;
      data_ff <= 1'b0;
    end
    else if (i_ce)
    begin
      if (cs_fall)
      begin
        shift_ff <= angle_ff;
        data_ff <= 1'b0;
      end
      else if (!cs_s2_ff && sclk_fall)
      begin
        data_ff <= shift_ff[rpo_pkg::ANGLE_W-1];
        shift_ff <= {shift_ff[rpo_pkg::ANGLE_W-2:0], 1'b0};
      end
    end
  end

  assign link.dev_data = data_ff;
  assign link.dev_data_oe = ~cs_s2_ff;

  assign o_a = a_ff;
  assign o_b = b_ff;
  assign o_dir = dir_ff;
  assign o_index_pulse = index_ff;
  assign o_lsb_step_pulse = pulse_ff;
  assign o_enc_valid = valid_ff;
  assign o_angle = angle_ff;

endmodule

`default_nettype wire

/* File: logic/rpo_host.sv */
/*
  Host end: word FIFO and the serial read master that fills it.
  Assumes the device end and the interface resolve the data wire, and
  that the user drains words on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none

module rpo_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [W-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [W-1:0] o_out_data
);

  // Depth must be a power of two so the pointers wrap by themselves.
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [AW:0] cnt_ff;
  logic push;
  logic pop;

  assign o_in_ready = cnt_ff != (AW+1)'(DEPTH);
  assign o_out_valid = cnt_ff != '0;
  assign push = i_in_valid & o_in_ready & i_ce;
  assign pop = o_out_valid & i_out_ready & i_ce;
  assign o_out_data = mem[rd_ff];

  always_ff @(posedge i_clk)
  begin
    if (push)
      mem[wr_ff] <= i_in_data;
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      if (push)
        wr_ff <= wr_ff + 1'b1;
      if (pop)
        rd_ff <= rd_ff + 1'b1;
      if (push && !pop)
        cnt_ff <= cnt_ff + 1'b1;
      else if (pop && !push)
        cnt_ff <= cnt_ff - 1'b1;
    end
  end

endmodule

module rpo_host (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic i_start,
  input wire logic [4:0] i_nbits,
  output logic o_start_ready,
  output logic o_busy,
  output logic o_word_valid,
  input wire logic i_word_ready,
  output logic [rpo_pkg::WORD_W-1:0] o_word,
  rpo_if.host link
);

  rpo_pkg::rpo_hst_e state_ff;
  logic [rpo_pkg::TMR_W-1:0] tmr_ff;
  logic [4:0] bits_ff;
  logic [rpo_pkg::WORD_W-1:0] rx_ff;
  logic cs_n_ff;
  logic sclk_ff;
  logic push_ff;
  logic dat_s1_ff;
  logic dat_s2_ff;
  logic fifo_ready;

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      dat_s1_ff <= 1'b0;
      dat_s2_ff <= 1'b0;
    end
    else if (i_ce)
    begin
      dat_s1_ff <= link.data_line;
      dat_s2_ff <= dat_s1_ff;
    end
  end

  // A read starts only with room for its word, so the push never stalls.
  assign o_start_ready = (state_ff == rpo_pkg::H_IDLE) & fifo_ready;
  assign o_busy = state_ff != rpo_pkg::H_IDLE;

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      state_ff <= rpo_pkg::H_IDLE;
      tmr_ff <= '0;
      bits_ff <= '0;
      rx_ff <= '0;
      cs_n_ff <= 1'b1;
      sclk_ff <= 1'b1;
      push_ff <= 1'b0;
    end
    else if (i_ce)
    begin
      push_ff <= 1'b0;
      case (state_ff)
        rpo_pkg::H_IDLE:
        begin
          if (i_start && o_start_ready)
          begin
            cs_n_ff <= 1'b0;
            bits_ff <= (i_nbits == 5'h00) ? rpo_pkg::FULL_BITS : i_nbits;
            rx_ff <= '0;
            tmr_ff <= rpo_pkg::TMR_W'(rpo_pkg::SETUP_CYC - 1);
            state_ff <= rpo_pkg::H_SETUP;
          end
        end
        rpo_pkg::H_SETUP:
        begin
          if (tmr_ff == '0)
          begin
            sclk_ff <= 1'b0;
            tmr_ff <= rpo_pkg::TMR_W'(rpo_pkg::SCLK_HALF_CYC - 1);
            state_ff <= rpo_pkg::H_LOW;
          end
          else
            tmr_ff <= tmr_ff - 8'h01;
        end
        rpo_pkg::H_LOW:
        begin
          if (tmr_ff == '0)
          begin
            sclk_ff <= 1'b1;
            rx_ff <= {rx_ff[rpo_pkg::WORD_W-2:0], dat_s2_ff};
            bits_ff <= bits_ff - 5'h01;
            tmr_ff <= rpo_pkg::TMR_W'(rpo_pkg::SCLK_HALF_CYC - 1);
            state_ff <= rpo_pkg::H_HIGH;
          end
          else
            tmr_ff <= tmr_ff - 8'h01;
        end
        rpo_pkg::H_HIGH:
        begin
          if (tmr_ff == '0)
          begin
            if (bits_ff != 5'h00)
            begin
              sclk_ff <= 1'b0;
              tmr_ff <= rpo_pkg::TMR_W'(rpo_pkg::SCLK_HALF_CYC - 1);
              state_ff <= rpo_pkg::H_LOW;
            end
            else
            begin
              tmr_ff <= rpo_pkg::TMR_W'(rpo_pkg::HOLD_CYC - 1);
              state_ff <= rpo_pkg::H_HOLD;
            end
          end
          else
            tmr_ff <= tmr_ff - 8'h01;
        end
        rpo_pkg::H_HOLD:
        begin
          if (tmr_ff == '0)
          begin
            cs_n_ff <= 1'b1;
            push_ff <= 1'b1;
            tmr_ff <= rpo_pkg::TMR_W'(rpo_pkg::GAP_CYC - 1);
            state_ff <= rpo_pkg::H_GAP;
          end
          else
            tmr_ff <= tmr_ff - 8'h01;
        end
        rpo_pkg::H_GAP:
        begin
          if (tmr_ff == '0)
            state_ff <= rpo_pkg::H_IDLE;
          else
            tmr_ff <= tmr_ff - 8'h01;
        end
        default:
          state_ff <= rpo_pkg::H_IDLE;
      endcase
    end
  end

  assign link.cs_n = cs_n_ff;
  assign link.sclk = sclk_ff;

  rpo_fifo #(
    .W(rpo_pkg::WORD_W),
    .DEPTH(rpo_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_ce(i_ce),
    .i_in_valid(push_ff),
    .o_in_ready(fifo_ready),
    .i_in_data(rx_ff),
    .o_out_valid(o_word_valid),
    .i_out_ready(i_word_ready),
    .o_out_data(o_word)
  );

endmodule

`default_nettype wire

/* File: bench/rpo_link_chk.sv */
/*
  Checker on the serial link between the position device and the host.
  Assumes one shared clock and the interface signals as plain inputs.
*/
`timescale 1ns/1ns
`default_nettype none

module rpo_link_chk (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic dev_data,
  input wire logic dev_data_oe,
  input wire logic data_line
);
  logic sclk_q_ff;
  logic [4:0] falls_ff;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      sclk_q_ff <= 1'b1;
    else
      sclk_q_ff <= sclk;
  end

  // Saturates so that a long overrun cannot wrap back into the word.
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      falls_ff <= 5'h00;
    else if (cs_n)
      falls_ff <= 5'h00;
    else if (sclk_q_ff && !sclk && falls_ff != 5'h1f)
      falls_ff <= falls_ff + 5'h01;
  end

  sequence s_quiet;
    cs_n [*3];
  endsequence
  sequence s_setup;
    sclk [*8] ##1 sclk [*7];
  endsequence

  property p_undriven;
    s_quiet |-> !dev_data_oe && !data_line;
  endproperty
  property p_enable;
    $fell(cs_n) |-> ##2 dev_data_oe;
  endproperty
  property p_void;
    $fell(cs_n) |-> ##3 !dev_data;
  endproperty
  property p_low_phase;
    $fell(sclk) |=> !sclk [*6];
  endproperty
  property p_high_phase;
    $rose(sclk) |=> sclk [*6];
  endproperty
  property p_setup;
    $fell(cs_n) |-> s_setup;
  endproperty
  property p_settled;
    $fell(sclk) |-> ##4 $stable(data_line) [*3];
  endproperty
  property p_framed;
    $fell(sclk) |-> !cs_n && dev_data_oe;
  endproperty
  property p_zeros;
    $rose(sclk) && falls_ff > 5'h0c |-> !data_line;
  endproperty
  property p_hold;
    $rose(cs_n) |-> $past(sclk, 1) && $past(sclk, 2) && $past(sclk, 3);
  endproperty
  property p_gap;
    $rose(cs_n) |=> cs_n [*6];
  endproperty

  a_undriven: assert property (p_undriven)
    else $error("data wire driven while deselected");
  a_enable: assert property (p_enable)
    else $error("data output not enabled after select");
  a_void: assert property (p_void)
    else $error("data bit not cleared after capture");
  a_low_phase: assert property (p_low_phase)
    else $error("shift clock low phase too short");
  a_high_phase: assert property (p_high_phase)
    else $error("shift clock high phase too short");
  a_setup: assert property (p_setup)
    else $error("shift clock began too soon after select");
  a_settled: assert property (p_settled)
    else $error("data bit unsettled before sampling");
  a_framed: assert property (p_framed)
    else $error("shift clock fell outside a frame");
  a_zeros: assert property (p_zeros)
    else $error("overrun bit not zero");
  a_hold: assert property (p_hold)
    else $error("select released too soon after last bit");
  a_gap: assert property (p_gap)
    else $error("select reapplied too soon");
endmodule

`default_nettype wire

/* File: bench/testbench.sv */
/*
  Self-checking bench joining the device and host ends over the link.
  Assumes both ends share one clock; a model tracks the angle and words.
*/
`timescale 1ns/1ns
`default_nettype none

module testbench;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic ce = 1'b1;
  logic stp = 1'b0;
  logic up = 1'b0;
  logic sv = 1'b0;
  logic [1:0] sel = 2'h0;
  logic start = 1'b0;
  logic [4:0] nb = 5'h00;
  logic rdy = 1'b0;
  logic a, b, dir, idx, pls, ev, srdy, busy, wv;
  logic [11:0] ang_o;
  logic [15:0] word;
  logic [15:0] q[$];
  int ang = 0;
  int mdir = 1;
  int mismatches = 0;
  int checks_done = 0;
  int cyc = 0;
  int k;
  int j;

  rpo_if i_rpo_if ();
  rpo_device i_rpo_device (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(ce),
    .i_step(stp), .i_step_up(up), .i_sig_valid(sv), .i_idx_width_sel(sel),
    .link(i_rpo_if), .o_a(a), .o_b(b), .o_dir(dir), .o_index_pulse(idx),
    .o_lsb_step_pulse(pls), .o_enc_valid(ev), .o_angle(ang_o));
  rpo_host i_rpo_host (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(ce),
    .i_start(start), .i_nbits(nb), .o_start_ready(srdy), .o_busy(busy),
    .o_word_valid(wv), .i_word_ready(rdy), .o_word(word), .link(i_rpo_if));
  rpo_link_chk i_rpo_link_chk (.i_clk(i_clk), .i_nrst(i_nrst),
    .cs_n(i_rpo_if.cs_n), .sclk(i_rpo_if.sclk),
    .dev_data(i_rpo_if.dev_data), .dev_data_oe(i_rpo_if.dev_data_oe),
    .data_line(i_rpo_if.data_line));

  initial
  begin
    forever #20 i_clk = ~i_clk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    if (mismatches == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic step(input logic u);
    @(negedge i_clk);
    stp = 1'b1;
    up = u;
    sv = 1'($urandom);
    @(negedge i_clk);
    stp = 1'b0;
    ang = (ang + (u ? 1 : 4095)) % 4096;
    mdir = u;
    chk(16'(ev), 16'(sv));
    chk(16'(pls), 16'h1);
    repeat (7) @(negedge i_clk);
    chk(16'(pls), 16'h1);
    @(negedge i_clk);
    chk(16'(pls), 16'h0);
    chk(16'(ang_o), 16'(ang));
    // Rising angle walks A,B through 00, 01, 11, 10, so B leads A.
    chk(16'({a, b}), 16'((ang % 4) == 2 ? 3 : (ang % 4) == 3 ? 2 :
      ang % 4));
    chk(16'(dir), 16'(mdir));
    // Open pin reads as the positive level, hence the narrow default.
    chk(16'(idx), 16'(ang < (sel == 2'h1 ? 2 : sel == 2'h2 ? 4 : 1)));
  endtask

  task automatic rd(input logic [4:0] n);
    for (k = 0; k < 99 && srdy !== 1'b1; k++)
      @(negedge i_clk);
    start = 1'b1;
    nb = n;
    @(negedge i_clk);
    start = 1'b0;
    q.push_back(16'((longint'(ang) << (n == 5'h00 ? 12 : n)) >> 12));
    // A 31-bit read takes about 460 cycles, so the wait must cover that.
    for (k = 0; k < 600 && busy !== 1'b0; k++)
      @(negedge i_clk);
    chk(16'(busy), 16'h0);
  endtask

  task automatic drain();
    while (wv === 1'b1 && q.size() > 0)
    begin
      chk(word, q.pop_front());
      rdy = 1'b1;
      @(negedge i_clk);
    end
    rdy = 1'b0;
    chk(16'({q.size(), wv}), 16'h0);
  endtask

  always @(posedge i_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      mismatches++;
      conclude();
    end
  end

  initial
  begin
    k = $urandom(32'h4fb1);
    repeat (6) @(negedge i_clk);
    i_nrst = 1'b1;
    chk(16'({a, b, dir, pls, srdy, busy, wv}), 16'h0014);
    for (j = 0; j < 4; j++)
    begin
      sel = 2'(j);
      repeat (2) step(1'b0);
      repeat (5) step(1'b1);
      repeat (3) step(1'($urandom));
    end
    ce = 1'b0;
    stp = 1'b1;
    @(negedge i_clk);
    stp = 1'b0;
    ce = 1'b1;
    @(negedge i_clk);
    chk(16'(ang_o), 16'(ang));
    for (j = 0; j < 16; j++)
    begin
      step(1'($urandom));
      rd(5'($urandom));
    end
    chk(16'(srdy), 16'h0);
    drain();
    i_nrst = 1'b0;
    @(negedge i_clk);
    i_nrst = 1'b1;
    ang = 0;
    chk(16'({ang_o, dir}), 16'h1);
    step(1'b0);
    rd(5'h0c);
    rd(5'h10);
    rd(5'h01);
    drain();
    conclude();
  end
endmodule

`default_nettype wire
